//--- adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
// ==========================================
// timing
`define ADCC_CLK_PERIOD_NS 8
`define ADCC_POR_TIME_NS 10000
`define ADCC_POR_CYCLES ((`ADCC_POR_TIME_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
// ==========================================
// control word layout
`define ADCC_CW_START 7
`define ADCC_CW_PICK_HI 6
`define ADCC_CW_PICK_LO 4
`define ADCC_CW_POLARITY 3
`define ADCC_CW_INCFG 2
`define ADCC_CW_PM_HI 1
`define ADCC_CW_PM_LO 0
`define ADCC_CW_BITS 8
`define ADCC_TRACK_BIT 5
// ==========================================
// conversion sequence
`define ADCC_RES_BITS 12
`define ADCC_STEP_FIRST_DEC 2
`define ADCC_STEP_TRAIL 14
`define ADCC_RESTART_BIT 6
// ==========================================
// reset values
`define ADCC_PM_RESET 2'b11
`endif

//--- adcc_pkg.sv
package adcc_pkg;
  typedef enum logic [1:0] {
    PM_FULL_POWER_DOWN = 2'b00,
    PM_FAST_POWER_DOWN = 2'b01,
    PM_REDUCED_POWER = 2'b10,
    PM_NORMAL = 2'b11
  } adcc_pmode_t;
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_SHUT
  } adcc_conv_t;
endpackage : adcc_pkg

//--- adcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // ==========================================
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : adcc_sync
`default_nettype wire

//--- adcc_top.sv
// Function
// - pseudo-differential picks: 001 in0+/in1-, 010 in2+/in3-, 101 in1+/in0-, 110 in3+/in2-
// - track on falling edge after bit five, hold after bit eight
// - single-ended ties negative side to common; differential converts the difference
// - with chip select low, shift data in on each rising serial clock
// - leading zeros ignored; first one is the control word msb
// - result bytes carry three leading zeros, twelve result bits, one trailing zero
// - unipolar straight binary, bipolar two's complement, msb first on rising edges
// - strobe high one clock after last control bit, then twelve decisions
// - outputs float with chip select high; strobe driven low after it falls
// - conversion starts on falling edge after bit eight, not on chip select
// - start bit when idle, or after result bit six of a running conversion
// - an accepted conversion is aborted only by the shutdown input
// - at most one conversion per sixteen clocks; free-running host sends 16 zeros
// - after power-on: normal mode, strobe low, zeros out, no starts for 10 us
// - software power mode applies after conversion; shutdown overrides at once
// - control word: start, channel pick, polarity, input config, power mode
// - polarity 1 unipolar, 0 bipolar; config 1 single-ended, 0 pseudo-differential
// - power mode 00 full down, 01 fast down, 10 reduced, 11 normal
// - single-ended picks: 001 in0, 101 in1, 010 in2, 110 in3 against common
// - low shutdown input powers the device down
// - power mode of last control word holds until a new one arrives
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"
module adcc_top #(
  parameter int POR_CYCLES = `ADCC_POR_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  input wire logic SHUTDOWN_N,
  input wire logic COMP_HIGH,
  output logic DOUT_O,
  output logic DOUT_OE,
  output logic STRB_O,
  output logic STRB_OE,
  output logic TRACK,
  output logic HOLD,
  output logic [1:0] POS_CH,
  output logic [1:0] NEG_CH,
  output logic NEG_COM,
  output logic CHAN_VALID,
  output logic UNIPOLAR,
  output logic [11:0] DAC_CODE,
  output logic [11:0] RESULT,
  output logic RESULT_VALID,
  output logic [1:0] POWER_MODE,
  output logic POWER_DOWN,
  output logic BUSY,
  output logic READY
);
  // all ones is the load sentinel of the hold-off counter, so it cannot be a count
  if (POR_CYCLES < 1 || POR_CYCLES > 65534)
  begin : g_bad_por
    $error("POR_CYCLES out of range");
  end
  // ==========================================
  // pin synchronisation and edge detection
  logic [4:0] pins_s;
  logic sclk_s, cs_n_s, din_s, shutdown_n_n_s, comp_s;
  logic sclk_prev_q, cs_n_prev_q;
  logic rise, fall;
  adcc_sync #(.W(5)) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d({SCLK, ~CS_N, DIN, ~SHUTDOWN_N, COMP_HIGH}),
    .q(pins_s)
  );
  // select and shutdown pass inverted: reset reads as deselected and running
  assign sclk_s = pins_s[4];
  assign cs_n_s = ~pins_s[3];
  assign din_s = pins_s[2];
  assign shutdown_n_n_s = ~pins_s[1];
  assign comp_s = pins_s[0];
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;
  // ==========================================
  // power-on hold-off
  logic [15:0] por_cnt_q;
  logic por_busy;
  assign por_busy = por_cnt_q != 16'h0000;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      por_cnt_q <= 16'hFFFF;
    else if (por_cnt_q == 16'hFFFF)
      por_cnt_q <= 16'(POR_CYCLES);
    else if (por_busy)
      por_cnt_q <= por_cnt_q - 16'h0001;
  end
  // ==========================================
  // channel decode
  function automatic logic [5:0] chan_decode(input logic [2:0] pick, input logic sgl);
    // returns {valid, neg_com, pos[1:0], neg[1:0]}
    logic [5:0] r;
    r = 6'b00_0000;
    unique case (pick)
      3'b001: r = sgl ? 6'b11_0000 : 6'b10_0001;
      3'b101: r = sgl ? 6'b11_0100 : 6'b10_0100;
      3'b010: r = sgl ? 6'b11_1000 : 6'b10_1011;
      3'b110: r = sgl ? 6'b11_1100 : 6'b10_1110;
      default: r = 6'b00_0000;
    endcase
    return r;
  endfunction : chan_decode
  // ==========================================
  // control word collection
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ctrl_q;
  logic start_ok, shift_en, word_done;
  adcc_pkg::adcc_conv_t conv_q;
  logic past_six_q;
  assign shift_en = rise & ~cs_n_s & shutdown_n_n_s & ~por_busy;
  assign start_ok = (conv_q != adcc_pkg::CONV_RUN) | past_six_q;
  assign word_done = fall & (bit_cnt_q == 4'(`ADCC_CW_BITS)) & shutdown_n_n_s;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end
    else if (!shutdown_n_n_s)
    begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end
    else if (word_done)
      bit_cnt_q <= 4'h0;
    else if (shift_en)
    begin
      if (bit_cnt_q == 4'h0)
      begin
        if (din_s && start_ok)
        begin
          bit_cnt_q <= 4'h1;
          shift_q <= 8'h01;
        end
      end
      else if (bit_cnt_q < 4'(`ADCC_CW_BITS))
      begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q <= {shift_q[6:0], din_s};
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl_q <= {1'b0, 3'b001, 1'b1, 1'b1, `ADCC_PM_RESET};
    else if (word_done)
      ctrl_q <= shift_q;
  end
  // ==========================================
  // track and hold
  logic track_q, hold_q;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      track_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else if (!shutdown_n_n_s)
    begin
      track_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else if (fall && bit_cnt_q == 4'(`ADCC_TRACK_BIT))
      track_q <= 1'b1;
    else if (word_done)
    begin
      track_q <= 1'b0;
      hold_q <= 1'b1;
    end
    else if (conv_q != adcc_pkg::CONV_RUN)
      hold_q <= 1'b0;
  end
  // ==========================================
  // conversion sequencer
  // the serial clock is the only timebase for decisions, so a slow host
  // directly stretches the hold interval and droop with it
  logic [3:0] step_q;
  logic [11:0] trial_q;
  logic [11:0] res_q;
  logic res_valid_q;
  logic bipolar;
  logic [3:0] dec_bit;
  logic is_dec;
  assign bipolar = ~ctrl_q[`ADCC_CW_POLARITY];
  assign is_dec = (step_q >= 4'(`ADCC_STEP_FIRST_DEC)) && (step_q < 4'(`ADCC_STEP_TRAIL));
  assign dec_bit = 4'(`ADCC_RES_BITS + `ADCC_STEP_FIRST_DEC - 1) - step_q;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      conv_q <= adcc_pkg::CONV_IDLE;
      step_q <= 4'h0;
      trial_q <= 12'h000;
      res_q <= 12'h000;
      res_valid_q <= 1'b0;
      past_six_q <= 1'b0;
    end
    else if (!shutdown_n_n_s)
    begin
      conv_q <= adcc_pkg::CONV_SHUT;
      step_q <= 4'h0;
      past_six_q <= 1'b0;
    end
    else if (word_done)
    begin
      conv_q <= adcc_pkg::CONV_RUN;
      step_q <= 4'h0;
      trial_q <= 12'h800;
      past_six_q <= 1'b0;
    end
    else
    begin
      unique case (conv_q)
        adcc_pkg::CONV_SHUT: conv_q <= adcc_pkg::CONV_IDLE;
        adcc_pkg::CONV_IDLE: step_q <= 4'h0;
        adcc_pkg::CONV_RUN:
        begin
          if (rise)
          begin
            step_q <= step_q + 4'h1;
            if (is_dec)
            begin
              res_q[dec_bit] <= comp_s;
              trial_q[dec_bit] <= comp_s;
              if (dec_bit != 4'h0)
                trial_q[dec_bit - 4'h1] <= 1'b1;
              if (dec_bit == 4'(`ADCC_RESTART_BIT))
                past_six_q <= 1'b1;
            end
            if (step_q == 4'(`ADCC_STEP_TRAIL))
            begin
              conv_q <= adcc_pkg::CONV_IDLE;
              res_valid_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  // ==========================================
  // serial output and strobe
  logic dout_q, strb_q;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      dout_q <= 1'b0;
    else if (!shutdown_n_n_s || word_done)
      dout_q <= 1'b0;
    else if (rise && conv_q == adcc_pkg::CONV_RUN)
    begin
      if (is_dec)
        dout_q <= comp_s ^ (bipolar && dec_bit == 4'(`ADCC_RES_BITS - 1));
      else
        dout_q <= 1'b0;
    end
    else if (rise)
      dout_q <= 1'b0;
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      strb_q <= 1'b0;
    else if (!shutdown_n_n_s)
      strb_q <= 1'b0;
    else if (word_done)
      strb_q <= 1'b1;
    else if (fall || (cs_n_prev_q && !cs_n_s))
      strb_q <= 1'b0;
  end
  assign DOUT_O = dout_q;
  assign STRB_O = strb_q;
  assign DOUT_OE = ~cs_n_s;
  assign STRB_OE = ~cs_n_s;
  // ==========================================
  // power mode and status
  logic [5:0] chan;
  assign chan = chan_decode(ctrl_q[`ADCC_CW_PICK_HI:`ADCC_CW_PICK_LO], ctrl_q[`ADCC_CW_INCFG]);
  always_comb
  begin
    if (!shutdown_n_n_s)
      POWER_MODE = adcc_pkg::PM_FULL_POWER_DOWN;
    else if (conv_q == adcc_pkg::CONV_RUN || bit_cnt_q != 4'h0 || por_busy)
      POWER_MODE = adcc_pkg::PM_NORMAL;
    else
      POWER_MODE = ctrl_q[`ADCC_CW_PM_HI:`ADCC_CW_PM_LO];
  end
  assign POWER_DOWN = ~shutdown_n_n_s;
  assign CHAN_VALID = chan[5];
  assign NEG_COM = chan[4];
  assign POS_CH = chan[3:2];
  assign NEG_CH = chan[1:0];
  assign UNIPOLAR = ctrl_q[`ADCC_CW_POLARITY];
  assign TRACK = track_q;
  assign HOLD = hold_q;
  assign DAC_CODE = trial_q;
  assign RESULT = res_q;
  assign RESULT_VALID = res_valid_q;
  assign BUSY = (conv_q == adcc_pkg::CONV_RUN) & shutdown_n_n_s;
  assign READY = ~por_busy;
endmodule : adcc_top
`default_nettype wire

//--- adcc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// port checks of the converter control block
module adcc_props (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_N,
  input wire logic DOUT_OE,
  input wire logic STRB_OE,
  input wire logic STRB_O,
  input wire logic TRACK,
  input wire logic HOLD,
  input wire logic [1:0] POS_CH,
  input wire logic [1:0] NEG_CH,
  input wire logic NEG_COM,
  input wire logic CHAN_VALID,
  input wire logic [11:0] DAC_CODE,
  input wire logic [1:0] POWER_MODE,
  input wire logic POWER_DOWN,
  input wire logic BUSY,
  input wire logic READY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // ====
  // assertions
  oe_pair_a: assert property (DOUT_OE == STRB_OE)
    else $error("strobe and data enables differ");
  cs_float_a: assert property (CS_N [*3] |=> !DOUT_OE)
    else $error("outputs driven while deselected");
  strb_pulse_a: assert property ($rose(STRB_O) |=> STRB_O [*8] ##[1:20] !STRB_O)
    else $error("strobe width not one serial clock");
  strb_cause_a: assert property ($rose(STRB_O) |-> ##[0:1] (HOLD && BUSY && !TRACK))
    else $error("strobe without hold and conversion");
  hold_track_a: assert property ($rose(HOLD) |-> $past(TRACK))
    else $error("hold entered without tracking");
  dac_start_a: assert property ($rose(BUSY) |-> DAC_CODE == 12'h800)
    else $error("first trial code wrong");
  busy_pm_a: assert property (BUSY |-> POWER_MODE == 2'h3)
    else $error("low power during conversion");
  shut_stop_a: assert property (POWER_DOWN [*2] |-> !BUSY && !HOLD && POWER_MODE == 2'h0)
    else $error("shutdown did not stop conversion");
  por_idle_a: assert property (!READY |-> !BUSY && !STRB_O)
    else $error("activity during power-on hold-off");
  pair_ok_a: assert property (CHAN_VALID && !NEG_COM |-> POS_CH[1] == NEG_CH[1] && POS_CH[0] != NEG_CH[0])
    else $error("differential pair not adjacent");
endmodule : adcc_props
bind adcc_top adcc_props adcc_props_i (.CLK(CLK), .RST_B(RST_B), .CS_N(CS_N),
  .DOUT_OE(DOUT_OE), .STRB_OE(STRB_OE), .STRB_O(STRB_O), .TRACK(TRACK), .HOLD(HOLD),
  .POS_CH(POS_CH), .NEG_CH(NEG_CH), .NEG_COM(NEG_COM), .CHAN_VALID(CHAN_VALID),
  .DAC_CODE(DAC_CODE), .POWER_MODE(POWER_MODE), .POWER_DOWN(POWER_DOWN), .BUSY(BUSY),
  .READY(READY));
`default_nettype wire

//--- adcc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// serial host: clock idle low, data set on fall, sampled on rise
module adcc_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    din = 1'h0;
  end
  task automatic sel(input logic v);
    cs_n = v;
  endtask : sel
  // 8 MHz bit rate keeps a 32-bit frame far inside the droop limit
  task automatic frame(input logic [31:0] bits, input int n, output logic [15:0] got);
    got = '0;
    cs_n = 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = bits[i];
      #62.5 sclk = 1'h1;
      got = {got[14:0], dout};
      #62.5 sclk = 1'h0;
    end
    din = ~din;
  endtask : frame
endmodule : adcc_host
`default_nettype wire

//--- adcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb;
  logic clk, rst_b, shutdown_n, comp_high, sclk, cs_n, din, dout_o, dout_oe, dout_w;
  logic strb_o, strb_oe, track, hold, neg_com, chan_valid, unipolar, result_valid;
  logic power_down, busy, ready;
  logic [1:0] pos_ch, neg_ch, power_mode;
  logic [11:0] dac_code, result, vin;
  logic [15:0] got;
  logic [2:0] picks [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  logic [1:0] poss [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  logic [1:0] negs [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  logic [11:0] vals [4] = '{12'h000, 12'hFFF, 12'h800, 12'h5A3};
  int err_total = 0;
  int tests_run = 0;
  adcc_top #(.POR_CYCLES(4)) adcc_top_i (.CLK(clk), .RST_B(rst_b), .SCLK(sclk),
    .CS_N(cs_n), .DIN(din), .SHUTDOWN_N(shutdown_n), .COMP_HIGH(comp_high),
    .DOUT_O(dout_o), .DOUT_OE(dout_oe), .STRB_O(strb_o), .STRB_OE(strb_oe),
    .TRACK(track), .HOLD(hold), .POS_CH(pos_ch), .NEG_CH(neg_ch), .NEG_COM(neg_com),
    .CHAN_VALID(chan_valid), .UNIPOLAR(unipolar), .DAC_CODE(dac_code),
    .RESULT(result), .RESULT_VALID(result_valid), .POWER_MODE(power_mode),
    .POWER_DOWN(power_down), .BUSY(busy), .READY(ready));
  // floating line shows the inverse so stale data cannot pass
  assign dout_w = dout_oe ? dout_o : ~dout_o;
  adcc_host adcc_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // comparator stand-in
  always @(negedge clk) comp_high <= (vin >= dac_code);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wait_idle;
    int n = 0;
    while (!(ready === 1'h1 && busy === 1'h0))
    begin
      @(negedge clk);
      n++;
      if (n > 300)
      begin
        err_total++;
        complete_run();
      end
    end
    repeat (8) @(negedge clk);
  endtask : wait_idle
  task automatic convert(input logic [7:0] w, input logic [11:0] v);
    logic [11:0] code;
    vin = v;
    adcc_host_i.frame({8'h00, w, 16'h0000}, 32, got);
    wait_idle();
    code = w[3] ? v : {~v[11], v[10:0]};
    check("dout", got, {3'h0, code, 1'h0});
    check("result", result, v);
    check("rvalid", result_valid, 1'h1);
    check("unipolar", unipolar, w[3]);
    check("neg_com", neg_com, w[2]);
    check("pmode", power_mode, w[1:0]);
  endtask : convert
  initial
  begin
    rst_b = 1'h0;
    shutdown_n = 1'h1;
    vin = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    wait_idle();
    check("strb", strb_o, 1'h0);
    check("pmode", power_mode, 2'h3);
    check("rvalid", result_valid, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      convert({1'h1, picks[i], i[1], i[0], i[1:0]}, vals[i]);
      check("pos", pos_ch, poss[i]);
      if (!i[0]) check("neg", neg_ch, negs[i]);
      check("valid", chan_valid, 1'h1);
    end
    adcc_host_i.frame({16'h0000, 8'h8F, 8'hFF}, 16, got);
    adcc_host_i.sel(1'h1);
    repeat (4) @(negedge clk);
    check("busy", busy, 1'h1);
    shutdown_n = 1'h0;
    repeat (6) @(negedge clk);
    check("busy", busy, 1'h0);
    check("pd", {power_down, power_mode}, 3'h4);
    shutdown_n = 1'h1;
    repeat (4) @(negedge clk);
    adcc_host_i.frame(32'h0, 16, got);
    check("idle", {busy, hold}, 2'h0);
    adcc_host_i.sel(1'h1);
    repeat (4) @(negedge clk);
    check("oe", dout_oe, 1'h0);
    adcc_host_i.sel(1'h0);
    repeat (4) @(negedge clk);
    check("oe", {dout_oe, strb_oe, strb_o}, 3'h6);
    complete_run();
  end
endmodule : adcc_top_tb
`default_nettype wire
